// ### sh_pkg.sv
// shared types and timing constants for the static memory host controller
package sh_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANES  = 2;

    // ------------------------------------------------------------
    // timing in ns and the cycle counts derived from it
    // ------------------------------------------------------------
    localparam int CLK_NS      = 10;
    localparam int T_AA_NS     = 55;
    localparam int T_PWE_NS    = 40;
    localparam int T_HZOE_NS   = 20;
    localparam int SYNC_STAGES = 2;
    localparam int TMR_W       = 4;
    localparam int RD_CYC      = (T_AA_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWE_CYC     = (T_PWE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TURN_CYC    = (T_HZOE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [TMR_W-1:0] RD_LOAD =
        TMR_W'(RD_CYC + SYNC_STAGES);
    localparam logic [TMR_W-1:0] PWE_LOAD  = TMR_W'(PWE_CYC - 1);
    localparam logic [TMR_W-1:0] TURN_LOAD = TMR_W'(TURN_CYC - 1);

    // ------------------------------------------------------------
    // reset values of the pins (deselected, nothing driven)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              we;
        logic [LANES-1:0]  be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sh_req_t;

    typedef struct packed {
        logic              select_active_low;
        logic              select_active_high;
        logic              write_strobe_n;
        logic              output_gate_n;
        logic              upper_lane_enable_n;
        logic              lower_lane_enable_n;
        logic [ADDR_W-1:0] addr;
    } sh_pins_t;

    localparam sh_pins_t PINS_RST = '{
        select_active_low:   1'b1,
        select_active_high:  1'b0,
        write_strobe_n:      1'b1,
        output_gate_n:       1'b1,
        upper_lane_enable_n: 1'b1,
        lower_lane_enable_n: 1'b1,
        addr:                ADDR_RST
    };

    typedef enum logic [2:0] {
        SH_IDLE,
        SH_RD_WAIT,
        SH_RD_TURN,
        SH_WR_SETUP,
        SH_WR_PULSE,
        SH_WR_HOLD
    } sh_state_t;

endpackage

// ### sh_timer.sv
// down counter that times the read wait, read turnaround and write strobe phases of a memory cycle
`timescale 1ns/100ps
module sh_timer #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    // control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    // status
    output logic              o_done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } sh_tmr_t;

    sh_tmr_t r;
    sh_tmr_t next_r;

    always_comb begin
        next_r = r;
        if (i_load) begin
            next_r.cnt = i_count;
        end else if (r.cnt != '0) begin
            next_r.cnt = r.cnt - W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_done = (r.cnt == '0);
endmodule // sh_timer

// ### sh_host.sv
// host controller driving an asynchronous 64K x 16 static memory
//
// How it works
// - a write needs both selects active, the strobe low and a lane enabled.
// - a read needs both selects active, the gate low and the strobe high.
// - write data is set up and held about the edge that ends the write.
// - the host never drives the bus while the memory may still drive it.
`timescale 1ns/100ps
module sh_host (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    // user request
    input  wire logic                  i_req_valid,
    input  wire sh_pkg::sh_req_t       i_req,
    output logic                       o_req_ready,
    // user read answer
    output logic                       o_rvalid,
    output logic [sh_pkg::DATA_W-1:0]  o_rdata,
    // memory pins
    output sh_pkg::sh_pins_t           o_pins,
    input  wire logic [sh_pkg::DATA_W-1:0] i_dq,
    output logic [sh_pkg::DATA_W-1:0]  o_dq,
    output logic                       o_dq_oe
);
    import sh_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sh_state_t         st;
        sh_pins_t          pins;
        logic [DATA_W-1:0] dq;
        logic              dq_oe;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } sh_host_t;

    sh_host_t         r;
    sh_host_t         next_r;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic             tmr_done;

    sh_timer #(
        .W (TMR_W)
    ) u_timer (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_load   (tmr_load),
        .i_count  (tmr_count),
        .o_done   (tmr_done)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.rvalid = 1'b0;
        next_r.sync1  = i_dq;
        next_r.sync2  = r.sync1;
        tmr_load      = 1'b0;
        tmr_count     = '0;
        case (r.st)
            SH_IDLE: begin
                // no lane means a deselected device: nothing to run
                if (i_req_valid && (i_req.be != '0)) begin
                    next_r.pins.select_active_low   = 1'b0;
                    next_r.pins.select_active_high  = 1'b1;
                    next_r.pins.addr                = i_req.addr;
                    next_r.pins.lower_lane_enable_n = !i_req.be[0];
                    next_r.pins.upper_lane_enable_n = !i_req.be[1];
                    if (i_req.we) begin
                        // gate stays high, so the memory cannot drive
                        next_r.dq    = i_req.wdata;
                        next_r.dq_oe = 1'b1;
                        next_r.st    = SH_WR_SETUP;
                    end else begin
                        next_r.pins.output_gate_n = 1'b0;
                        tmr_load  = 1'b1;
                        tmr_count = RD_LOAD;
                        next_r.st = SH_RD_WAIT;
                    end
                end
            end
            SH_RD_WAIT: begin
                // access time plus the input synchroniser depth
                if (tmr_done) begin
                    next_r.rdata = r.sync2 & {
                        {8{!r.pins.upper_lane_enable_n}},
                        {8{!r.pins.lower_lane_enable_n}}};
                    next_r.rvalid = 1'b1;
                    next_r.pins   = PINS_RST;
                    tmr_load      = 1'b1;
                    tmr_count     = TURN_LOAD;
                    next_r.st     = SH_RD_TURN;
                end
            end
            SH_RD_TURN: begin
                // let the memory release the bus before we may drive
                if (tmr_done) begin
                    next_r.st = SH_IDLE;
                end
            end
            SH_WR_SETUP: begin
                next_r.pins.write_strobe_n = 1'b0;
                tmr_load  = 1'b1;
                tmr_count = PWE_LOAD;
                next_r.st = SH_WR_PULSE;
            end
            SH_WR_PULSE: begin
                // strobe edge ends the write; data still held
                if (tmr_done) begin
                    next_r.pins.write_strobe_n = 1'b1;
                    next_r.st = SH_WR_HOLD;
                end
            end
            SH_WR_HOLD: begin
                // one hold cycle, then release bus and selects together
                next_r.pins  = PINS_RST;
                next_r.dq_oe = 1'b0;
                next_r.st    = SH_IDLE;
            end
            default: begin
                next_r.st = SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r.st     <= SH_IDLE;
            r.pins   <= PINS_RST;
            r.dq     <= DATA_RST;
            r.dq_oe  <= 1'b0;
            r.rdata  <= DATA_RST;
            r.rvalid <= 1'b0;
            r.sync1  <= DATA_RST;
            r.sync2  <= DATA_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_req_ready = (r.st == SH_IDLE);
    assign o_rvalid    = r.rvalid;
    assign o_rdata     = r.rdata;
    assign o_pins      = r.pins;
    assign o_dq        = r.dq;
    assign o_dq_oe     = r.dq_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    a_write_select_ok: assert property (
        !r.pins.write_strobe_n |-> !r.pins.select_active_low
            && r.pins.select_active_high
            && !(r.pins.upper_lane_enable_n
                 && r.pins.lower_lane_enable_n))
        else $error("strobe low without a full select");

    a_read_select_ok: assert property (
        !r.pins.output_gate_n |-> r.pins.write_strobe_n
            && !r.pins.select_active_low && r.pins.select_active_high)
        else $error("gate low outside a proper read");

    a_no_bus_fight: assert property (
        r.dq_oe |-> r.pins.output_gate_n)
        else $error("host drives while gate is low");

    a_gate_turnaround: assert property (
        $rose(r.pins.output_gate_n) |-> !r.dq_oe [*3])
        else $error("bus driven too soon after a read");

    a_strobe_width: assert property (
        $fell(r.pins.write_strobe_n) |-> !r.pins.write_strobe_n [*4]
            ##1 r.pins.write_strobe_n)
        else $error("write strobe width wrong");

    a_data_hold: assert property (
        $rose(r.pins.write_strobe_n) |-> r.dq_oe && $stable(r.dq)
            && !r.pins.select_active_low)
        else $error("write data not held at strobe end");

    a_data_setup: assert property (
        $fell(r.pins.write_strobe_n) |-> r.dq_oe
            && $past(r.dq_oe) && $stable(r.dq))
        else $error("write data not set up before strobe");

    a_read_answer: assert property (
        $fell(r.pins.output_gate_n) |-> ##9 r.rvalid)
        else $error("read answer late or early");

    c_read: cover property ($fell(r.pins.output_gate_n) ##[1:12] r.rvalid);
    c_write: cover property ($rose(r.pins.write_strobe_n));
    c_byte_write: cover property (
        !r.pins.write_strobe_n && r.pins.upper_lane_enable_n);
    c_back_to_back: cover property (r.rvalid ##[1:4] !r.dq_oe ##1 r.dq_oe);
endmodule // sh_host

// ### sh_mem_model.sv
// behavioural model of the 64K x 16 static memory seen at its pins
`timescale 1ns/100ps
module sh_mem_model #(
    parameter int ACC_NS = 55
) (
    // control pins
    input  wire sh_pkg::sh_pins_t  i_pins,
    // data bus
    input  wire logic [15:0]       i_bus,
    output logic [15:0]            o_q,
    output logic [1:0]             o_drive
);
    import sh_pkg::*;
    // ------------------------------------------------------------
    // array and decode
    // ------------------------------------------------------------
    logic [15:0] mem [0:65535];
    logic        sel;
    logic        wr;
    logic        rd;
    logic        rd_late;
    logic [15:0] word;
    logic        up_n;
    logic        lo_n;
    assign up_n = i_pins.upper_lane_enable_n;
    assign lo_n = i_pins.lower_lane_enable_n;
    assign sel  = !i_pins.select_active_low && i_pins.select_active_high
                  && !(up_n && lo_n);
    assign wr   = sel && !i_pins.write_strobe_n;
    assign rd   = sel && i_pins.write_strobe_n
                  && !i_pins.output_gate_n;
    // data only appears after the access time, so a hasty sample fails
    assign #(ACC_NS) rd_late = rd;
    assign word = mem[i_pins.addr];
    // ------------------------------------------------------------
    // read drive, released lanes show the inverse of the stored byte
    // ------------------------------------------------------------
    assign o_drive = {2{rd && rd_late}} & ~{up_n, lo_n};
    assign o_q = {o_drive[1] ? word[15:8] : ~word[15:8],
                  o_drive[0] ? word[7:0] : ~word[7:0]};
    // ------------------------------------------------------------
    // level write, last data before the ending edge stays stored
    // ------------------------------------------------------------
    always @(wr, i_bus, i_pins) begin
        if (wr && !lo_n) mem[i_pins.addr][7:0] = i_bus[7:0];
        if (wr && !up_n) mem[i_pins.addr][15:8] = i_bus[15:8];
    end
endmodule // sh_mem_model

// ### sh_host_tb.sv
// self-checking testbench for the static memory host controller
`timescale 1ns/100ps
module sh_host_tb;
    import sh_pkg::*;
    logic              i_clk;
    logic              i_resetn;
    logic              i_req_valid;
    sh_req_t           i_req;
    logic              o_req_ready;
    logic              o_rvalid;
    logic              o_dq_oe;
    logic [DATA_W-1:0] o_rdata;
    logic [DATA_W-1:0] o_dq;
    logic [DATA_W-1:0] i_dq;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] rd_word;
    sh_pins_t          o_pins;
    logic [1:0]        mem_drive;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int low_cnt;
    int sel_cnt;
    int rv_cnt;

    sh_host dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_rvalid(o_rvalid),
        .o_rdata(o_rdata), .o_pins(o_pins), .i_dq(i_dq),
        .o_dq(o_dq), .o_dq_oe(o_dq_oe));
    sh_mem_model #(.ACC_NS(55)) mem_u (.i_pins(o_pins), .i_bus(i_dq),
        .o_q(mem_q), .o_drive(mem_drive));
    assign i_dq = o_dq_oe ? o_dq : mem_q;

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one request, then watch the pins until the controller is idle
    task automatic xfer(logic we, logic [1:0] be, logic [15:0] a, d);
        int n;
        @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req = '{we: we, be: be, addr: a, wdata: d};
        @(negedge i_clk);
        i_req_valid = 1'b0;
        {low_cnt, sel_cnt, rv_cnt, n} = '0;
        rd_word = 'x;
        while (o_req_ready !== 1'b1 && n < 20) begin
            if (o_rvalid === 1'b1) rd_word = o_rdata;
            rv_cnt += int'(o_rvalid === 1'b1);
            low_cnt += int'(o_pins.write_strobe_n === 1'b0);
            sel_cnt += int'(o_pins.select_active_low === 1'b0);
            @(negedge i_clk);
            n++;
        end
        chk("ready", 1'h1, o_req_ready);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("pins", 32'(PINS_RST), 32'(o_pins));
        chk("dq_oe", 1'h0, o_dq_oe);
    endtask

    task automatic t_word;
        xfer(1'b1, 2'h3, 16'hA55A, 16'h1234);
        chk("strobe", PWE_CYC, low_cnt);
        xfer(1'b0, 2'h3, 16'hA55A, 16'h0000);
        chk("word", 16'h1234, rd_word);
        chk("strobe", 32'h0, low_cnt);
    endtask

    task automatic t_lanes;
        xfer(1'b1, 2'h3, 16'hFFFF, 16'hABCD);
        xfer(1'b1, 2'h1, 16'hFFFF, 16'h1122);
        xfer(1'b1, 2'h2, 16'hFFFF, 16'h3344);
        xfer(1'b0, 2'h3, 16'hFFFF, 16'h0000);
        chk("lanes", 16'h3322, rd_word);
        xfer(1'b0, 2'h1, 16'hFFFF, 16'h0000);
        chk("low", 16'h0022, rd_word);
        xfer(1'b0, 2'h2, 16'hFFFF, 16'h0000);
        chk("high", 16'h3300, rd_word);
    endtask

    task automatic t_empty;
        xfer(1'b1, 2'h0, 16'hFFFF, 16'h5555);
        chk("sel", 32'h0, sel_cnt + low_cnt);
        xfer(1'b0, 2'h0, 16'hFFFF, 16'h0000);
        chk("rvalid", 32'h0, rv_cnt);
        xfer(1'b0, 2'h3, 16'hFFFF, 16'h0000);
        chk("kept", 16'h3322, rd_word);
    endtask

    task automatic t_reread;
        xfer(1'b1, 2'h3, 16'h0000, 16'h0F0F);
        xfer(1'b0, 2'h3, 16'h0000, 16'h0000);
        xfer(1'b0, 2'h3, 16'h0000, 16'h0000);
        chk("reread", 16'h0F0F, rd_word);
    endtask

    // reset in the middle of a read must idle the pins and keep the array
    task automatic t_midreset;
        @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req = '{we: 1'b0, be: 2'h3, addr: 16'h0000, wdata: 16'h0000};
        @(negedge i_clk);
        i_req_valid = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("gate", 1'h0, o_pins.output_gate_n);
        i_resetn = 1'b0;
        @(negedge i_clk);
        chk("rst_pins", 32'(PINS_RST), 32'(o_pins));
        chk("rst_ready", 1'h1, o_req_ready);
        chk("rst_rvalid", 1'h0, o_rvalid);
        i_resetn = 1'b1;
        xfer(1'b0, 2'h3, 16'h0000, 16'h0000);
        chk("after_rst", 16'h0F0F, rd_word);
    endtask

    // ------------------------------------------------------------
    // bus fight and hang watch
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (i_resetn && o_dq_oe === 1'b1 && mem_drive !== 2'b00) begin
            mismatches++;
            $display("BAD bus expected %h seen %h", 2'b00, mem_drive);
        end
        if (cycles == 2000) begin
            mismatches++;
            end_of_test;
        end
    end

    initial begin
        i_resetn = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        repeat (5) @(negedge i_clk);
        i_resetn = 1'b1;
        t_reset;
        t_word;
        t_lanes;
        t_empty;
        t_reread;
        t_midreset;
        end_of_test;
    end
endmodule // sh_host_tb
